// ### logic/dlpui_pkg.sv
// Shared constants and types for the die link power-up and init block
package dlpui_pkg;
	// Number of lane groups in the link instance
	localparam int NUM_LG = 8;
	// Core clock period
	localparam int CLK_PERIOD_NS = 50;
	// Least reset hold time kept by the anchor
	localparam int RESET_HOLD_US = 200;
	localparam int RESET_HOLD_CYC =
		(RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] RESET_HOLD_CNT = 12'(RESET_HOLD_CYC);
	// Least lead of the parked transmit clock before reset release
	localparam int CLK_PARK_LEAD_NS = 10;
	localparam int CLK_PARK_LEAD_CYC =
		((CLK_PARK_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
		(CLK_PARK_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Local settling time before configuration is allowed
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [4:0] SETTLE_CNT = 5'(SETTLE_CYC);
	// Register indexes on the configuration port
	localparam logic [7:0] IDX_BUS_TRAITS = 8'h00;
	localparam logic [7:0] IDX_DEV_TYPE = 8'h01;
	localparam logic [7:0] IDX_LG_DIR = 8'h02;
	localparam logic [7:0] IDX_LG_CFG_DONE = 8'h03;
	localparam logic [7:0] IDX_CONTROL = 8'h04;
	localparam logic [7:0] IDX_STATUS = 8'h05;
	// Bus traits fields
	localparam logic [1:0] ROLE_TARGET = 2'h0;
	localparam logic [1:0] ROLE_CONTROLLER = 2'h1;
	localparam logic ADV_CAPABLE = 1'h1;
	localparam logic VIRT_TARGET = 1'h0;
	localparam logic OFFLINE_CAPABLE = 1'h0;
	localparam logic IBI_PAYLOAD = 1'h1;
	localparam logic IBI_CAPABLE = 1'h1;
	localparam logic SPEED_LIMIT = 1'h0;
	localparam logic [7:0] BUS_TRAITS_VALUE = {ROLE_TARGET, ADV_CAPABLE,
		VIRT_TARGET, OFFLINE_CAPABLE, IBI_PAYLOAD, IBI_CAPABLE, SPEED_LIMIT};
	// Serial frame layout
	localparam logic [3:0] LAST_DATA_POS = 4'h7;
	localparam logic [3:0] ACK_POS = 4'h8;
	localparam logic [1:0] BYTE_ADDR = 2'h0;
	localparam logic [1:0] BYTE_INDEX = 2'h1;
	localparam logic [1:0] BYTE_DATA = 2'h2;
	// Control register bit for the mission request
	localparam int CTRL_MISSION_BIT = 0;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_HOLD,
		ST_SETTLE,
		ST_READY,
		ST_MISSION
	} dlpui_state_t;
	// Settings written over the port, carried to the core clock
	typedef struct packed {
		logic missionReq;
		logic [NUM_LG-1:0] cfgDone;
		logic [NUM_LG-1:0] dir;
	} dlpui_ctl_t;
	// Core state reported back to the port
	typedef struct packed {
		logic mission;
		logic ready;
		logic shortReset;
		logic linkReset;
		logic powerGood;
	} dlpui_stat_t;
endpackage : dlpui_pkg

// ### logic/dlpui_power_up_init.sv
// Die link power-up sequencer with its configuration port registers

// Three-stage synchroniser; a bit changes once stages two and three agree
module dlpui_sync3 #(
	parameter int W = 1
) (
	input wire logic dstClk,
	input wire logic resetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_ff; // First stage, read only by the second
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff; // Qualified value

	// Shift chain
	always_ff @(posedge dstClk or negedge resetn) begin
		if (!resetn) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Take a bit only where the last two stages agree
	always_ff @(posedge dstClk or negedge resetn) begin
		if (!resetn) begin
			q_ff <= '0;
		end else begin
			q_ff <= (s3_ff & ~(s2_ff ^ s3_ff)) | (q_ff & (s2_ff ^ s3_ff));
		end
	end

	assign dout = q_ff;
endmodule : dlpui_sync3

// Top level of the chiplet side
module dlpui_power_up_init #(
	parameter logic [6:0] TARGET_ADDR = 7'h2c, // Static port address
	parameter logic [7:0] DEVICE_TYPE_CODE = 8'h5a // Arbitrary value
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic powerGoodIn,
	input wire logic cctResetIn,
	input wire logic cctSclIn,
	input wire logic cctSdaIn,
	output logic cctSdaOut,
	output logic cctSdaOeN,
	output logic [dlpui_pkg::NUM_LG-1:0] laneTxDir,
	output logic [dlpui_pkg::NUM_LG-1:0] txClkTrue,
	output logic [dlpui_pkg::NUM_LG-1:0] txClkComp,
	output logic readyToConfig,
	output logic missionActive
);
	import dlpui_pkg::*;

	// Port side, clocked by the serial clock
	logic [3:0] bitPos_ff; // Bit within the current byte
	logic [1:0] byteIdx_ff; // Byte within the frame
	logic [6:0] shift_ff; // Incoming bits
	logic addrMatch_ff; // Frame is for this device
	logic readNotWrite_ff; // Frame direction
	logic [7:0] regIdx_ff; // Addressed register
	logic [7:0] readData_ff; // Outgoing read byte
	logic sdaOut_ff; // Open drain level, always low
	logic sdaOeN_ff; // Low while pulling the line
	dlpui_ctl_t ctlScl_ff; // Written settings
	dlpui_stat_t statScl; // Core state seen from the port
	logic [7:0] rxByte; // Byte completing at this edge
	logic byteDone; // Last data bit of a byte
	logic writeHit; // Write data byte landing

	// Core side
	logic [1:0] pinQ; // Synced reset and power-good
	logic linkReset; // Anchor reset, active high
	logic powerGood;
	dlpui_ctl_t ctlClk; // Settings seen from the core
	logic allCfgDone; // Every lane group finished
	logic missionOk; // Mission may run
	dlpui_state_t state_ff;
	logic [4:0] settleCnt_ff;
	logic [11:0] resetCnt_ff; // Reset length so far
	logic resetSeen_ff; // Reset was high last cycle
	logic shortReset_ff; // Last reset shorter than hold time
	dlpui_stat_t stat_ff;
	logic [NUM_LG-1:0] laneTxDir_ff;
	logic [NUM_LG-1:0] txClkTrue_ff;
	logic [NUM_LG-1:0] txClkComp_ff;
	logic ready_ff;
	logic mission_ff;

	assign rxByte = {shift_ff, cctSdaIn};
	assign byteDone = (bitPos_ff == LAST_DATA_POS);
	assign writeHit = byteDone && (byteIdx_ff == BYTE_DATA) &&
		addrMatch_ff && !readNotWrite_ff;

	// Read decode of every register
	function automatic logic [7:0] readMux(input logic [7:0] idx,
		input dlpui_ctl_t ctl, input dlpui_stat_t st);
		logic [7:0] val;
		val = 8'h00;
		unique case (idx)
			IDX_BUS_TRAITS: val = BUS_TRAITS_VALUE;
			IDX_DEV_TYPE: val = DEVICE_TYPE_CODE;
			IDX_LG_DIR: val = ctl.dir;
			IDX_LG_CFG_DONE: val = ctl.cfgDone;
			IDX_CONTROL: val = {7'h00, ctl.missionReq};
			IDX_STATUS: val = {3'h0, st};
			default: val = 8'h00;
		endcase
		return val;
	endfunction : readMux

	// Frame position; frames are three bytes with acknowledge slots
	always_ff @(posedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			bitPos_ff <= 4'h0;
			byteIdx_ff <= BYTE_ADDR;
		end else if (bitPos_ff == ACK_POS) begin
			bitPos_ff <= 4'h0;
			byteIdx_ff <= (byteIdx_ff == BYTE_DATA) ? BYTE_ADDR :
				byteIdx_ff + 2'h1;
		end else begin
			bitPos_ff <= bitPos_ff + 4'h1;
		end
	end

	// Collect incoming data bits
	always_ff @(posedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			shift_ff <= 7'h00;
		end else if (bitPos_ff != ACK_POS) begin
			shift_ff <= rxByte[6:0];
		end
	end

	// Address byte and register index
	always_ff @(posedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			addrMatch_ff <= 1'b0;
			readNotWrite_ff <= 1'b0;
			regIdx_ff <= 8'h00;
		end else if (byteDone && byteIdx_ff == BYTE_ADDR) begin
			addrMatch_ff <= (rxByte[7:1] == TARGET_ADDR);
			readNotWrite_ff <= rxByte[0];
		end else if (byteDone && byteIdx_ff == BYTE_INDEX) begin
			regIdx_ff <= rxByte;
		end
	end

	// Load the read byte, then shift it out most significant first
	always_ff @(posedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			readData_ff <= 8'h00;
		end else if (byteDone && byteIdx_ff == BYTE_INDEX) begin
			readData_ff <= readMux(rxByte, ctlScl_ff, statScl);
		end else if (byteIdx_ff == BYTE_DATA && bitPos_ff != ACK_POS) begin
			readData_ff <= {readData_ff[6:0], 1'b0};
		end
	end

	// Writable settings; direction resets to receive
	always_ff @(posedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			ctlScl_ff <= '0;
		end else if (writeHit) begin
			unique case (regIdx_ff)
				IDX_LG_DIR: ctlScl_ff.dir <= rxByte;
				IDX_LG_CFG_DONE: ctlScl_ff.cfgDone <= rxByte;
				IDX_CONTROL: ctlScl_ff.missionReq <= rxByte[CTRL_MISSION_BIT];
				default: ctlScl_ff <= ctlScl_ff;
			endcase
		end
	end

	// Line drive on the falling edge: acknowledge and read bits
	always_ff @(negedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			sdaOeN_ff <= 1'b1;
		end else if (bitPos_ff == ACK_POS) begin
			// Answer every addressed frame in any state
			sdaOeN_ff <= !(addrMatch_ff && (byteIdx_ff != BYTE_DATA ||
				!readNotWrite_ff));
		end else if (byteIdx_ff == BYTE_DATA && addrMatch_ff &&
			readNotWrite_ff) begin
			sdaOeN_ff <= readData_ff[7];
		end else begin
			sdaOeN_ff <= 1'b1;
		end
	end

	// Open drain never drives high
	always_ff @(negedge cctSclIn or negedge resetn) begin
		if (!resetn) begin
			sdaOut_ff <= 1'b0;
		end else begin
			sdaOut_ff <= 1'b0;
		end
	end

	// Core state into the port domain
	dlpui_sync3 #(.W($bits(dlpui_stat_t))) statSync (
		.dstClk(cctSclIn),
		.resetn(resetn),
		.din(stat_ff),
		.dout(statScl)
	);

	// Anchor pins into the core domain
	dlpui_sync3 #(.W(2)) pinSync (
		.dstClk(clk),
		.resetn(resetn),
		.din({cctResetIn, powerGoodIn}),
		.dout(pinQ)
	);

	// Written settings into the core domain, each bit a level
	dlpui_sync3 #(.W($bits(dlpui_ctl_t))) ctlSync (
		.dstClk(clk),
		.resetn(resetn),
		.din(ctlScl_ff),
		.dout(ctlClk)
	);

	assign linkReset = pinQ[1];
	assign powerGood = pinQ[0];
	assign allCfgDone = &ctlClk.cfgDone;
	assign missionOk = allCfgDone && ctlClk.missionReq;

	// Sequencer: hold, settle, ready, mission
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_HOLD;
			settleCnt_ff <= 5'h00;
		end else if (linkReset || !powerGood) begin
			state_ff <= ST_HOLD;
			settleCnt_ff <= 5'h00;
		end else begin
			unique case (state_ff)
				ST_HOLD: begin
					state_ff <= ST_SETTLE;
				end
				ST_SETTLE: begin
					if (settleCnt_ff == SETTLE_CNT - 5'h01) begin
						state_ff <= ST_READY;
					end else begin
						settleCnt_ff <= settleCnt_ff + 5'h01;
					end
				end
				ST_READY: begin
					if (missionOk) begin
						state_ff <= ST_MISSION;
					end
				end
				ST_MISSION: begin
					if (!missionOk) begin
						state_ff <= ST_READY;
					end
				end
			endcase
		end
	end

	// Measure reset length; flag a release before the hold time
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			resetCnt_ff <= 12'h000;
			resetSeen_ff <= 1'b0;
			shortReset_ff <= 1'b0;
		end else begin
			resetSeen_ff <= linkReset;
			if (linkReset && !resetSeen_ff) begin
				// First high cycle already counts as one
				resetCnt_ff <= 12'h001;
				shortReset_ff <= 1'b0;
			end else if (linkReset && resetCnt_ff != RESET_HOLD_CNT) begin
				resetCnt_ff <= resetCnt_ff + 12'h001;
			end
			if (!linkReset && resetSeen_ff) begin
				shortReset_ff <= (resetCnt_ff != RESET_HOLD_CNT);
			end
		end
	end

	// Status, direction and flags
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stat_ff <= '0;
			laneTxDir_ff <= '0;
			ready_ff <= 1'b0;
			mission_ff <= 1'b0;
		end else begin
			stat_ff.mission <= (state_ff == ST_MISSION);
			stat_ff.ready <= (state_ff == ST_READY) ||
				(state_ff == ST_MISSION);
			stat_ff.shortReset <= shortReset_ff;
			stat_ff.linkReset <= linkReset;
			stat_ff.powerGood <= powerGood;
			laneTxDir_ff <= ctlClk.dir;
			ready_ff <= (state_ff == ST_READY) || (state_ff == ST_MISSION);
			mission_ff <= (state_ff == ST_MISSION);
		end
	end

	// Forwarded clock per lane group; parked low outside mission
	for (genvar g = 0; g < NUM_LG; g++) begin : gLaneClk
		always_ff @(posedge clk or negedge resetn) begin
			if (!resetn) begin
				txClkTrue_ff[g] <= 1'b0;
				txClkComp_ff[g] <= 1'b1;
			end else if (state_ff == ST_MISSION && ctlClk.dir[g]) begin
				txClkTrue_ff[g] <= ~txClkTrue_ff[g];
				txClkComp_ff[g] <= txClkTrue_ff[g];
			end else begin
				txClkTrue_ff[g] <= 1'b0;
				txClkComp_ff[g] <= 1'b1;
			end
		end
	end

	assign cctSdaOut = sdaOut_ff;
	assign cctSdaOeN = sdaOeN_ff;
	assign laneTxDir = laneTxDir_ff;
	assign txClkTrue = txClkTrue_ff;
	assign txClkComp = txClkComp_ff;
	assign readyToConfig = ready_ff;
	assign missionActive = mission_ff;

	// Index byte arriving for a given register
	logic idxArrive;
	assign idxArrive = byteDone && byteIdx_ff == BYTE_INDEX;

	sequence releaseSeq;
		(state_ff == ST_HOLD) ##1 (state_ff == ST_SETTLE);
	endsequence

	sequence settleRun;
		(state_ff == ST_SETTLE) [*8];
	endsequence

	park_in_reset_a: assert property (
		@(posedge clk) disable iff (!resetn)
		linkReset |=> (state_ff == ST_HOLD) ##1
			(txClkTrue_ff == '0 && txClkComp_ff == '1))
		else $error("transmit clock not parked during reset");

	hold_in_reset_a: assert property (
		@(posedge clk) disable iff (!resetn)
		(linkReset || !powerGood) |=> (state_ff == ST_HOLD) ##1
			(!ready_ff && !mission_ff))
		else $error("sequencer left hold during reset");

	settle_wait_a: assert property (
		@(posedge clk) disable iff (!resetn)
		releaseSeq |-> settleRun)
		else $error("settle phase ended early");

	mission_gate_a: assert property (
		@(posedge clk) disable iff (!resetn)
		$rose(mission_ff) |-> $past(allCfgDone, 2) && $past(ctlClk.missionReq, 2))
		else $error("mission entered before all lane groups done");

	traits_role_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(idxArrive && rxByte == IDX_BUS_TRAITS) |=>
			readData_ff[7:6] == ROLE_TARGET)
		else $error("device role field wrong");

	traits_high_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(idxArrive && rxByte == IDX_BUS_TRAITS) |=>
			readData_ff[5:3] == 3'h4)
		else $error("traits bits 5 to 3 wrong");

	traits_low_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(idxArrive && rxByte == IDX_BUS_TRAITS) |=>
			readData_ff[2:0] == 3'h6)
		else $error("traits bits 2 to 0 wrong");

	type_code_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(idxArrive && rxByte == IDX_DEV_TYPE) |=>
			readData_ff == DEVICE_TYPE_CODE)
		else $error("device type code wrong");

	dir_write_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(writeHit && regIdx_ff == IDX_LG_DIR) |=>
			ctlScl_ff.dir == $past(rxByte))
		else $error("direction write lost");

	status_read_a: assert property (
		@(posedge cctSclIn) disable iff (!resetn)
		(idxArrive && rxByte == IDX_STATUS) |=>
			readData_ff[4:0] == $past(statScl))
		else $error("status read wrong");

	ack_always_a: assert property (
		@(negedge cctSclIn) disable iff (!resetn)
		(bitPos_ff == ACK_POS && byteIdx_ff == BYTE_ADDR && addrMatch_ff)
			|=> !sdaOeN_ff)
		else $error("addressed frame not acknowledged");
endmodule : dlpui_power_up_init

// ### tb/dlpui_anchor_model.sv
// Anchor die model: power-good, link reset and configuration frames
module dlpui_anchor_model (
	input wire logic clk,
	input wire logic sdaLine,
	output logic powerGoodIn,
	output logic cctResetIn,
	output logic cctSclIn,
	output logic sdaHost,
	output logic [10:0] frameResult,
	output logic frameTgl
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SCL_HALF_NS = 40; // Half of the 80 ns link clock
	// Supplies ramping: power-good low, link clock parked high
	initial begin
		powerGoodIn = 1'b0;
		cctResetIn = 1'b0;
		cctSclIn = 1'b1;
		sdaHost = 1'b1;
		frameResult = 11'h0;
		frameTgl = 1'b0;
	end
	// Power stable: raise power-good and link reset together
	task automatic power_on();
		@(posedge clk);
		#2;
		powerGoodIn = 1'b1;
		cctResetIn = 1'b1;
	endtask : power_on
	// Hold link reset for a count of core cycles, then release
	task automatic link_reset(input int cyc);
		@(posedge clk);
		#2;
		cctResetIn = 1'b1;
		repeat (cyc) @(posedge clk);
		#2;
		cctResetIn = 1'b0;
	endtask : link_reset
	// One whole frame of 27 link clock pulses; host releases ack slots
	task automatic frame(input logic [6:0] addr, input logic rnw,
		input logic [7:0] idx, input logic [7:0] wdata);
		logic [26:0] drive;
		logic [26:0] seen;
		drive = {addr, rnw, 1'b1, idx, 1'b1, (rnw ? 8'hff : wdata), 1'b1};
		for (int i = 26; i >= 0; i--) begin
			cctSclIn = 1'b0;
			sdaHost = drive[i];
			#SCL_HALF_NS;
			cctSclIn = 1'b1;
			seen[i] = sdaLine;
			#SCL_HALF_NS;
		end
		// Released line returns to the pull-up level
		sdaHost = 1'b1;
		frameResult = {seen[18], seen[9], seen[0], seen[8:1]};
		frameTgl = ~frameTgl;
		// Idle gap so the next frame never redrives the line at once
		#SCL_HALF_NS;
	endtask : frame
endmodule : dlpui_anchor_model

// ### tb/dlpui_power_up_init_test.sv
// Self-checking bench for the die link power-up sequencer
module dlpui_power_up_init_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dlpui_pkg::*;
	localparam logic [6:0] ADDR = 7'h2c; // Static port address
	localparam logic [7:0] DEV_CODE = 8'h3c; // Arbitrary value
	localparam int TIMEOUT_CYC = 12000; // Run needs about 4850 cycles
	logic clk, resetn, powerGoodIn, cctResetIn, cctSclIn, sdaHost;
	logic cctSdaOut, cctSdaOeN, readyToConfig, missionActive, sdaLine;
	logic frameTgl;
	logic [NUM_LG-1:0] laneTxDir, txClkTrue, txClkComp, dirVal, clkA;
	logic [10:0] frameResult;
	logic [10:0] expQ[$]; // Expected {acks, data} of each frame
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	int n;
	// Open-drain wire with pull-up
	assign sdaLine = sdaHost & (cctSdaOeN | cctSdaOut);
	dlpui_power_up_init #(.TARGET_ADDR(ADDR), .DEVICE_TYPE_CODE(DEV_CODE))
		i_dut (.clk(clk), .resetn(resetn), .powerGoodIn(powerGoodIn),
		.cctResetIn(cctResetIn), .cctSclIn(cctSclIn), .cctSdaIn(sdaLine),
		.cctSdaOut(cctSdaOut), .cctSdaOeN(cctSdaOeN),
		.laneTxDir(laneTxDir), .txClkTrue(txClkTrue),
		.txClkComp(txClkComp), .readyToConfig(readyToConfig),
		.missionActive(missionActive));
	dlpui_anchor_model i_anchor (.clk(clk), .sdaLine(sdaLine),
		.powerGoodIn(powerGoodIn), .cctResetIn(cctResetIn),
		.cctSclIn(cctSclIn), .sdaHost(sdaHost),
		.frameResult(frameResult), .frameTgl(frameTgl));
	// Core clock, 50 ns
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Compare and count
	task automatic chk(input string name, input logic [15:0] seen,
		input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			err_count++;
		end
	endtask : chk
	// Verdict and end of run
	task automatic finish_test();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test
	// Register read and write frames, expectation noted first
	task automatic rd(input logic [6:0] a, input logic [7:0] idx,
		input logic [2:0] acks, input logic [7:0] exp);
		expQ.push_back({acks, exp});
		i_anchor.frame(a, 1'b1, idx, 8'h00);
	endtask : rd
	task automatic wr(input logic [6:0] a, input logic [7:0] idx,
		input logic [7:0] d, input logic [2:0] acks);
		expQ.push_back({acks, d});
		i_anchor.frame(a, 1'b0, idx, d);
	endtask : wr
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == TIMEOUT_CYC) begin
			err_count++;
			finish_test();
		end
	end
	// Frame monitor takes the oldest note
	always @(frameTgl) begin
		if (cycles > 0) begin
			if (expQ.size() == 0) begin
				chk("frameQueue", 16'h1, 16'h0);
			end else begin
				chk("frame", 16'(frameResult), 16'(expQ.pop_front()));
			end
		end
	end
	// Main sequence
	initial begin
		void'($urandom(26930));
		resetn = 1'b0;
		repeat (8) @(posedge clk);
		#2;
		chk("parkTrue", txClkTrue, 8'h00);
		chk("parkComp", txClkComp, 8'hff);
		chk("dirReset", laneTxDir, 8'h00);
		chk("idle", {missionActive, readyToConfig}, 2'h0);
		resetn = 1'b1;
		i_anchor.power_on();
		// Fixed registers, refused writes, foreign address, unmapped index
		rd(ADDR, IDX_BUS_TRAITS, 3'h1, 8'h26);
		wr(ADDR, IDX_BUS_TRAITS, 8'hd9, 3'h0);
		rd(ADDR, IDX_BUS_TRAITS, 3'h1, 8'h26);
		rd(ADDR, IDX_DEV_TYPE, 3'h1, DEV_CODE);
		wr(ADDR, IDX_DEV_TYPE, 8'hff, 3'h0);
		rd(ADDR, IDX_DEV_TYPE, 3'h1, DEV_CODE);
		rd(ADDR ^ 7'h01, IDX_BUS_TRAITS, 3'h7, 8'hff);
		rd(ADDR, 8'h47, 3'h1, 8'h00);
		chk("holdReady", readyToConfig, 1'b0);
		chk("holdPark", txClkComp, 8'hff);
		i_anchor.link_reset(RESET_HOLD_CYC);
		repeat (18) @(posedge clk);
		#2;
		chk("settle", readyToConfig, 1'b0);
		for (n = 0; n < 40 && readyToConfig !== 1'b1; n++) @(posedge clk);
		#2;
		chk("ready", readyToConfig, 1'b1);
		// Status after a full-length reset: ready, power good, no short flag
		rd(ADDR, IDX_STATUS, 3'h1, 8'h09);
		// Random direction, then refused and granted mission
		dirVal = 8'($urandom());
		wr(ADDR, IDX_LG_DIR, dirVal, 3'h0);
		rd(ADDR, IDX_LG_DIR, 3'h1, dirVal);
		chk("laneDir", laneTxDir, dirVal);
		wr(ADDR, IDX_LG_CFG_DONE, 8'hfe, 3'h0);
		wr(ADDR, IDX_CONTROL, 8'h01, 3'h0);
		repeat (20) @(posedge clk);
		#2;
		chk("noMission", missionActive, 1'b0);
		wr(ADDR, IDX_LG_CFG_DONE, 8'hff, 3'h0);
		repeat (10) @(posedge clk);
		#2;
		chk("mission", missionActive, 1'b1);
		clkA = txClkTrue;
		@(posedge clk);
		#2;
		chk("txToggle", clkA ^ txClkTrue, dirVal);
		chk("txComp", txClkComp, 8'(~txClkTrue));
		// Short link reset in mission parks the transmit clocks and drops ready and mission
		i_anchor.link_reset(30);
		chk("reParkT", txClkTrue, 8'h00);
		chk("reParkC", txClkComp, 8'hff);
		chk("reIdle", {missionActive, readyToConfig}, 2'h0);
		// Back in mission with the short reset flag raised
		repeat (40) @(posedge clk);
		#2;
		rd(ADDR, IDX_STATUS, 3'h1, 8'h1d);
		// Chip reset mid-run clears the direction register
		@(posedge clk);
		#2;
		resetn = 1'b0;
		repeat (2) @(posedge clk);
		#2;
		resetn = 1'b1;
		rd(ADDR, IDX_LG_DIR, 3'h1, 8'h00);
		chk("dirCleared", laneTxDir, 8'h00);
		repeat (2) @(posedge clk);
		chk("queueLeft", 16'(expQ.size()), 16'h0);
		finish_test();
	end
endmodule : dlpui_power_up_init_test
